// ---- embi_pkg.sv ----
// Shared constants and types for the external memory bus interface
package embi_pkg;
	localparam int EMBI_AW = 24;
	localparam int EMBI_DW = 16;
	localparam int EMBI_NCS = 4;
	// Strobe low time in clock cycles
	localparam int EMBI_STRB_CYC = 3;
	// Cycles the strap synchroniser settles before capture
	localparam logic [1:0] EMBI_STRAP_WAIT = 2'h3;
	// Strap level that selects the 8-bit bus
	localparam logic EMBI_STRAP_BUS8 = 1'b1;
	localparam logic [EMBI_AW-1:0] EMBI_ADDR_RST = 24'h00_0000;
	localparam logic [EMBI_NCS-1:0] EMBI_CS_IDLE = 4'hf;
	typedef enum logic [2:0] {
		ST_IDLE, ST_SETUP, ST_STRB, ST_RECOV, ST_REL, ST_GNT, ST_RECLAIM
	} embi_state_t;
endpackage

// ---- embi_area_dec.sv ----
// Address area decoder for chip selects and per-area bus width
`timescale 1ns/1ns
module embi_area_dec import embi_pkg::*; #(
	parameter int AW = EMBI_AW,
	parameter int N = EMBI_NCS
) (
	// Address under decode
	input wire logic [AW-1:0] addr,
	// Area configuration
	input wire logic [N*AW-1:0] area_base,
	input wire logic [N*AW-1:0] area_mask,
	input wire logic [N-1:0] area_en,
	input wire logic [N-1:0] area_bus16,
	input wire logic dflt_bus16,
	// Results
	output logic [N-1:0] hit,
	output logic bus16
);
	// An empty address or an empty area list leaves nothing to decode
	if (N < 1 || AW < 1) begin : g_chk
		$error("N and AW must be at least 1");
	end
	// One comparator per area; mask bits set mean do not care
	genvar g;
	for (g = 0; g < N; g++) begin : g_area
		assign hit[g] = area_en[g] &&
			(((addr ^ area_base[g*AW +: AW]) & ~area_mask[g*AW +: AW]) == '0);
	end
	// Lowest numbered hit sets the width, else the strap width
	always_comb begin
		bus16 = dflt_bus16;
		for (int i = N - 1; i >= 0; i--) begin
			if (hit[i]) begin
				bus16 = area_bus16[i];
			end
		end
	end
endmodule // embi_area_dec

// ---- embi_bus.sv ----
// External memory expansion bus: strobes, sizing, chip selects, bus hold
// Function
// - Direction output high on read and dummy cycles, low on writes.
// - Each chip select low while bus address is inside its area.
// - External controller requests the device float all bus pins.
// - Grant asserted only after the pins are floated.
// - Main write strobe pulses for writes on the low data byte.
// - High byte write strobe pulses for writes on the upper data byte.
// - Read strobe asserted during external fetch cycles.
// - Mixed 8 and 16 bit regions; accesses split or merged to fit.
// - Board strap sampled to pick 8 or 16 bit default bus width.
// - 24-bit address reaches 16 Mbytes.
// - Granted controller gets no path into internal memory or I/O.
// - DRAM strobes float during grant only in release mode.
`timescale 1ns/1ns
module embi_bus import embi_pkg::*; #(
	parameter int STRB_CYC = EMBI_STRB_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Core access port
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_word,
	input wire logic [EMBI_AW-1:0] req_addr,
	input wire logic [EMBI_DW-1:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic [EMBI_DW-1:0] rsp_rdata,
	// Area configuration
	input wire logic [EMBI_NCS*EMBI_AW-1:0] area_base,
	input wire logic [EMBI_NCS*EMBI_AW-1:0] area_mask,
	input wire logic [EMBI_NCS-1:0] area_en,
	input wire logic [EMBI_NCS-1:0] area_bus16,
	// DRAM controller signals
	input wire logic dram_release_mode,
	input wire logic dram_ras_n,
	input wire logic dram_cas_n,
	input wire logic dram_refresh_n,
	output logic row_strobe_n,
	output logic column_strobe_n,
	output logic refresh_cycle_indicator,
	output logic dram_oe,
	// Address and data pins
	output logic [EMBI_AW-1:0] addr_out,
	output logic addr_oe,
	input wire logic [EMBI_DW-1:0] data_in,
	output logic [EMBI_DW-1:0] data_out,
	output logic data_oe,
	// Strobe, direction and select pins
	output logic rd_n,
	output logic wr_n,
	output logic high_byte_write_strobe_n,
	output logic rw_dir,
	output logic area_select_zero_n,
	output logic area_select_one_n,
	output logic area_select_two_n,
	output logic area_select_three_n,
	output logic ctl_oe,
	// Bus hold and strap pins
	input wire logic bus_hold_request,
	output logic bus_hold_grant,
	input wire logic bus_width_strap
);
	if (STRB_CYC < 2 || STRB_CYC > 3) begin : g_chk
		$error("STRB_CYC must be 2 or 3");
	end
	localparam logic [1:0] STRB_LAST = 2'(STRB_CYC);

	embi_state_t state_r;
	logic [1:0] hreq_s, strap_s, cnt_r, strap_cnt_r;
	logic [EMBI_DW-1:0] din_s1, din_s2, wdata_r, rdata_r, rd_merge;
	logic [EMBI_AW-1:0] addr_r, addr_nxt;
	logic [EMBI_NCS-1:0] hit_w, cs_n_r;
	logic [7:0] wbyte, rbyte;
	logic strap_bus16_r, strap_done_r, bus16_w, bus16_r;
	logic wr_r, word_r, split_r, part_r, take, next_part, hi_lane, full;
	logic ready_r, grant_r, rsp_r, rd_n_r, wr_n_r, hwr_n_r, dir_r;
	logic addr_oe_r, ctl_oe_r, data_oe_r, dram_oe_r;
	logic [EMBI_DW-1:0] dout_r;
	logic ras_r, cas_r, ref_r;

	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge mclk) begin
		hreq_s <= {hreq_s[0], bus_hold_request};
		strap_s <= {strap_s[0], bus_width_strap};
		din_s1 <= data_in;
		din_s2 <= din_s1;
	end

	// Strap caught once after reset release, once the synchroniser settled
	always_ff @(posedge mclk) begin
		if (rst) begin
			strap_cnt_r <= 2'h0;
			strap_done_r <= 1'b0;
			strap_bus16_r <= 1'b0;
		end else if (!strap_done_r) begin
			if (strap_cnt_r == EMBI_STRAP_WAIT) begin
				strap_bus16_r <= (strap_s[1] != EMBI_STRAP_BUS8);
				strap_done_r <= 1'b1;
			end else begin
				strap_cnt_r <= strap_cnt_r + 2'h1;
			end
		end
	end

	assign take = (state_r == ST_IDLE) && req_valid && ready_r;
	assign next_part = (state_r == ST_RECOV) && split_r && !part_r;
	assign hi_lane = bus16_r && addr_r[0];
	assign full = word_r && !split_r;
	assign wbyte = part_r ? wdata_r[15:8] : wdata_r[7:0];
	assign rbyte = hi_lane ? din_s2[15:8] : din_s2[7:0];

	// Address for the next cycle; second part of a split steps by one
	always_comb begin
		addr_nxt = addr_r;
		if (take) begin
			addr_nxt = req_addr;
		end else if (next_part) begin
			addr_nxt = addr_r + 24'h00_0001;
		end
	end

	embi_area_dec #(.AW(EMBI_AW), .N(EMBI_NCS)) u_dec (
		.addr(addr_nxt),
		.area_base(area_base),
		.area_mask(area_mask),
		.area_en(area_en),
		.area_bus16(area_bus16),
		.dflt_bus16(strap_bus16_r),
		.hit(hit_w),
		.bus16(bus16_w)
	);

	// Address, width and selects follow the decoded address
	always_ff @(posedge mclk) begin
		if (rst) begin
			addr_r <= EMBI_ADDR_RST;
			bus16_r <= 1'b0;
			cs_n_r <= EMBI_CS_IDLE;
		end else begin
			addr_r <= addr_nxt;
			bus16_r <= bus16_w;
			cs_n_r <= ~hit_w;
		end
	end

	// Read data merge; a byte request returns zero in the top byte
	always_comb begin
		rd_merge = rdata_r;
		if (full) begin
			rd_merge = din_s2;
		end else if (part_r) begin
			rd_merge[15:8] = rbyte;
		end else begin
			rd_merge = {8'h00, rbyte};
		end
	end

	// Access sequencer and bus hold handshake
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_r <= ST_IDLE;
			cnt_r <= 2'h0;
			ready_r <= 1'b0;
			grant_r <= 1'b0;
			rsp_r <= 1'b0;
			part_r <= 1'b0;
			split_r <= 1'b0;
			wr_r <= 1'b0;
			word_r <= 1'b0;
			wdata_r <= '0;
			rdata_r <= '0;
		end else begin
			rsp_r <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (take) begin
						ready_r <= 1'b0;
						wr_r <= req_write;
						word_r <= req_word;
						wdata_r <= req_wdata;
						part_r <= 1'b0;
						split_r <= req_word && !(bus16_w && !req_addr[0]);
						state_r <= ST_SETUP;
					end else if (hreq_s[1]) begin
						ready_r <= 1'b0;
						state_r <= ST_REL;
					end else begin
						ready_r <= strap_done_r;
					end
				end
				ST_SETUP: begin
					cnt_r <= 2'h0;
					state_r <= ST_STRB;
				end
				ST_STRB: begin
					cnt_r <= cnt_r + 2'h1;
					if (cnt_r == STRB_LAST) begin
						state_r <= ST_RECOV;
					end
				end
				ST_RECOV: begin
					if (!wr_r) begin
						rdata_r <= rd_merge;
					end
					if (next_part) begin
						part_r <= 1'b1;
						state_r <= ST_SETUP;
					end else begin
						rsp_r <= 1'b1;
						state_r <= ST_IDLE;
					end
				end
				// Pins float here; grant follows a cycle later
				ST_REL: begin
					state_r <= ST_GNT;
				end
				ST_GNT: begin
					grant_r <= hreq_s[1];
					if (!hreq_s[1]) begin
						state_r <= ST_RECLAIM;
					end
				end
				ST_RECLAIM: begin
					state_r <= ST_IDLE;
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Pin drivers: strobes, data, direction and output enables
	always_ff @(posedge mclk) begin
		if (rst) begin
			rd_n_r <= 1'b1;
			wr_n_r <= 1'b1;
			hwr_n_r <= 1'b1;
			dir_r <= 1'b1;
			dout_r <= '0;
			data_oe_r <= 1'b0;
			addr_oe_r <= 1'b1;
			ctl_oe_r <= 1'b1;
			dram_oe_r <= 1'b1;
		end else begin
			case (state_r)
				ST_SETUP: begin
					dir_r <= !wr_r;
					data_oe_r <= wr_r;
					dout_r <= full ? wdata_r : (hi_lane ? {wbyte, 8'h00} : {8'h00, wbyte});
				end
				ST_STRB: begin
					if (cnt_r == 2'h0) begin
						rd_n_r <= wr_r;
						wr_n_r <= !(wr_r && (full || !hi_lane));
						hwr_n_r <= !(wr_r && (full || hi_lane));
					end else if (cnt_r == STRB_LAST) begin
						rd_n_r <= 1'b1;
						wr_n_r <= 1'b1;
						hwr_n_r <= 1'b1;
					end
				end
				ST_RECOV: begin
					data_oe_r <= 1'b0;
					dir_r <= 1'b1;
				end
				// Float everything the external controller may drive
				ST_REL: begin
					addr_oe_r <= 1'b0;
					ctl_oe_r <= 1'b0;
					dram_oe_r <= !dram_release_mode;
				end
				ST_RECLAIM: begin
					addr_oe_r <= 1'b1;
					ctl_oe_r <= 1'b1;
					dram_oe_r <= 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// DRAM strobes pass through a register stage
	always_ff @(posedge mclk) begin
		if (rst) begin
			ras_r <= 1'b1;
			cas_r <= 1'b1;
			ref_r <= 1'b1;
		end else begin
			ras_r <= dram_ras_n;
			cas_r <= dram_cas_n;
			ref_r <= dram_refresh_n;
		end
	end

	// No inbound path exists: a granted master cannot reach inside
	assign req_ready = ready_r;
	assign rsp_valid = rsp_r;
	assign rsp_rdata = rdata_r;
	assign addr_out = addr_r;
	assign addr_oe = addr_oe_r;
	assign data_out = dout_r;
	assign data_oe = data_oe_r;
	assign rd_n = rd_n_r;
	assign wr_n = wr_n_r;
	assign high_byte_write_strobe_n = hwr_n_r;
	assign rw_dir = dir_r;
	assign {area_select_three_n, area_select_two_n, area_select_one_n,
		area_select_zero_n} = cs_n_r;
	assign ctl_oe = ctl_oe_r;
	assign dram_oe = dram_oe_r;
	assign row_strobe_n = ras_r;
	assign column_strobe_n = cas_r;
	assign refresh_cycle_indicator = ref_r;
	assign bus_hold_grant = grant_r;

	property p_dir_wr;
		@(posedge mclk) disable iff (rst) (!wr_n_r || !hwr_n_r) |-> !dir_r && data_oe_r;
	endproperty
	a_dir_wr: assert property (p_dir_wr) else $error("write strobe with read direction");

	property p_cs;
		@(posedge mclk) disable iff (rst) !$past(rst) |-> cs_n_r == ~$past(hit_w);
	endproperty
	a_cs: assert property (p_cs) else $error("chip select disagrees with area");

	property p_grant;
		@(posedge mclk) disable iff (rst)
			$rose(grant_r) |-> !addr_oe_r && !ctl_oe_r && !data_oe_r && !$past(ctl_oe_r);
	endproperty
	a_grant: assert property (p_grant) else $error("grant before pins floated");

	property p_wr_pulse;
		@(posedge mclk) disable iff (rst) $fell(wr_n_r) |-> (!wr_n_r)[*3] ##1 wr_n_r;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe width wrong");

	property p_hwr;
		@(posedge mclk) disable iff (rst) !hwr_n_r |-> bus16_r && (full || addr_r[0]);
	endproperty
	a_hwr: assert property (p_hwr) else $error("high strobe on wrong lane");

	property p_rd;
		@(posedge mclk) disable iff (rst) $fell(rd_n_r) |-> dir_r && !data_oe_r ##[4:13] rsp_r;
	endproperty
	a_rd: assert property (p_rd) else $error("read strobe without completion");

	property p_split;
		@(posedge mclk) disable iff (rst) next_part |=> state_r == ST_SETUP && part_r;
	endproperty
	a_split: assert property (p_split) else $error("split access lost second part");

	property p_dram;
		@(posedge mclk) disable iff (rst) $fell(dram_oe_r) |-> $past(dram_release_mode);
	endproperty
	a_dram: assert property (p_dram) else $error("DRAM pins floated outside release mode");

	property p_boundary;
		@(posedge mclk) disable iff (rst)
			grant_r |-> rd_n_r && wr_n_r && hwr_n_r && !ready_r;
	endproperty
	a_boundary: assert property (p_boundary) else $error("grant during an access");

	property p_reclaim;
		@(posedge mclk) disable iff (rst) $fell(grant_r) |-> !ctl_oe_r ##1 ctl_oe_r && addr_oe_r;
	endproperty
	a_reclaim: assert property (p_reclaim) else $error("pins retaken out of order");
endmodule // embi_bus

// ---- embi_mem_model.sv ----
// External memory model hanging on the expansion bus pins
`timescale 1ns/1ns
module embi_mem_model import embi_pkg::*; (
	// Clock
	input wire logic mclk,
	// Bus pins from the device
	input wire logic [EMBI_AW-1:0] addr_out,
	input wire logic [EMBI_DW-1:0] data_out,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic high_byte_write_strobe_n,
	input wire logic ctl_oe,
	// Attached part width, 1 means 8-bit
	input wire logic narrow,
	// Data lines back to the device
	output logic [EMBI_DW-1:0] data_in
);
	logic [7:0] mem [0:255];
	logic [7:0] a;
	logic [EMBI_DW-1:0] last = 16'h5a3c;
	assign a = addr_out[7:0];
	// Store under each write strobe; pattern keeps idle lines from looking valid
	always_ff @(posedge mclk) begin
		if (ctl_oe && !wr_n) mem[narrow ? a : {a[7:1], 1'b0}] <= data_out[7:0];
		if (ctl_oe && !high_byte_write_strobe_n) mem[{a[7:1], 1'b1}] <= data_out[15:8];
		last <= ~last;
	end
	// Narrow part drives only the low lane
	always_comb begin
		if (ctl_oe && !rd_n && narrow) data_in = {last[15:8], mem[a]};
		else if (ctl_oe && !rd_n) data_in = {mem[{a[7:1], 1'b1}], mem[{a[7:1], 1'b0}]};
		else data_in = last;
	end
endmodule // embi_mem_model

// ---- embi_bus_test.sv ----
// Self-checking bench for the external memory bus interface
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module embi_bus_test;
	import embi_pkg::*;
	logic mclk, rst, req_valid, req_write, req_word, req_ready, rsp_valid;
	logic [23:0] req_addr, addr_out;
	logic [15:0] req_wdata, rsp_rdata, data_in, data_out;
	logic [95:0] area_base, area_mask;
	logic [3:0] area_en, area_bus16;
	logic [2:0] dram_in;
	wire [3:0] sel_n;
	wire [2:0] dram_q;
	logic dram_release_mode, dram_oe, addr_oe, data_oe, rd_n, wr_n, hbw_n, rw_dir, ctl_oe;
	logic bus_hold_request, bus_hold_grant, bus_width_strap, narrow, wr_q, hb_q, rd_q;
	int mismatches, samples_checked, n_wr, n_hb, n_rd;
	embi_bus dut_u (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
		.req_word(req_word), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .area_base(area_base),
		.area_mask(area_mask), .area_en(area_en), .area_bus16(area_bus16),
		.dram_release_mode(dram_release_mode), .dram_ras_n(dram_in[2]), .dram_cas_n(dram_in[1]),
		.dram_refresh_n(dram_in[0]), .row_strobe_n(dram_q[2]), .column_strobe_n(dram_q[1]),
		.refresh_cycle_indicator(dram_q[0]), .dram_oe(dram_oe), .addr_out(addr_out),
		.addr_oe(addr_oe),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe), .rd_n(rd_n), .wr_n(wr_n),
		.high_byte_write_strobe_n(hbw_n), .rw_dir(rw_dir), .area_select_zero_n(sel_n[0]),
		.area_select_one_n(sel_n[1]), .area_select_two_n(sel_n[2]),
		.area_select_three_n(sel_n[3]), .ctl_oe(ctl_oe), .bus_hold_request(bus_hold_request),
		.bus_hold_grant(bus_hold_grant), .bus_width_strap(bus_width_strap));
	embi_mem_model mem_u (.mclk(mclk), .addr_out(addr_out), .data_out(data_out), .rd_n(rd_n),
		.wr_n(wr_n), .high_byte_write_strobe_n(hbw_n), .ctl_oe(ctl_oe), .narrow(narrow),
		.data_in(data_in));
	// Clock
	initial begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	// Count strobe pulses and watch direction while strobes are low
	always @(negedge mclk) begin
		if (wr_q && !wr_n) n_wr++;
		if (hb_q && !hbw_n) n_hb++;
		if (rd_q && !rd_n) n_rd++;
		if (!wr_n || !hbw_n) `CHK(rw_dir, 1'b0)
		if (!rd_n) `CHK(rw_dir, 1'b1)
		wr_q = wr_n;
		hb_q = hbw_n;
		rd_q = rd_n;
	end
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// A wait ran out: count it and stop
	task automatic expire;
		mismatches++;
		$display("wrong value at %0t: wait ran out", $time);
		conclude();
	endtask
	// One core access, returns on the completion pulse
	task automatic acc(input logic w, input logic wd, input logic [23:0] ad, input logic [15:0] dt);
		int t;
		@(negedge mclk);
		n_wr = 0;
		n_hb = 0;
		n_rd = 0;
		req_valid = 1;
		req_write = w;
		req_word = wd;
		req_addr = ad;
		req_wdata = dt;
		for (t = 0; t < 50 && req_ready !== 1'b1; t++) @(negedge mclk);
		if (t == 50) expire();
		@(negedge mclk);
		req_valid = 0;
		for (t = 0; t < 50 && rsp_valid !== 1'b1; t++) @(negedge mclk);
		if (t == 50) expire();
	endtask
	task automatic t_reset;
		`CHK({rd_n, wr_n, hbw_n, rw_dir}, 4'hf)
		`CHK(sel_n, EMBI_CS_IDLE)
		`CHK(bus_hold_grant, 1'b0)
		// DRAM strobes come through one register stage
		dram_in = 3'h5;
		@(negedge mclk);
		`CHK(dram_q, 3'h5)
		dram_in = 3'h7;
		@(negedge mclk);
		`CHK(dram_q, 3'h7)
		$display("done reset");
	endtask
	// Both lanes, one cycle, 16-bit area zero
	task automatic t_word16;
		narrow = 0;
		acc(1, 1, 24'h000010, 16'hbeef);
		`CHK(n_wr, 1)
		`CHK(n_hb, 1)
		`CHK(sel_n, 4'he)
		acc(0, 1, 24'h000010, 16'h0000);
		`CHK(rsp_rdata, 16'hbeef)
		`CHK(n_rd, 1)
		$display("done word16");
	endtask
	// Odd byte goes on the upper lane only, even byte on the lower
	task automatic t_byte16;
		acc(1, 0, 24'h000021, 16'h0077);
		`CHK({n_wr, n_hb}, {32'd0, 32'd1})
		acc(1, 0, 24'h000020, 16'h0055);
		`CHK({n_wr, n_hb}, {32'd1, 32'd0})
		acc(0, 0, 24'h000021, 16'h0000);
		`CHK(rsp_rdata, 16'h0077)
		// Odd word in a 16-bit area: upper lane first, then lower lane
		acc(1, 1, 24'h000031, 16'hc0de);
		`CHK({n_wr, n_hb}, {32'd1, 32'd1})
		acc(0, 1, 24'h000031, 16'h0000);
		`CHK(rsp_rdata, 16'hc0de)
		`CHK(n_rd, 2)
		$display("done byte16");
	endtask
	// Word into 8-bit area one is split, strap area outside all areas too
	task automatic t_narrow(input logic [23:0] ad, input logic [3:0] sel);
		narrow = 1;
		acc(1, 1, ad, 16'h1234);
		`CHK({n_wr, n_hb}, {32'd2, 32'd0})
		`CHK(sel_n, sel)
		acc(0, 1, ad, 16'h0000);
		`CHK(rsp_rdata, 16'h1234)
		`CHK(n_rd, 2)
		$display("done narrow");
	endtask
	// Top of the 16 Mbyte space in area three
	task automatic t_top;
		narrow = 0;
		acc(1, 1, 24'hfffffe, 16'ha5c3);
		`CHK(addr_out, 24'hfffffe)
		`CHK(sel_n, 4'h7)
		acc(0, 1, 24'hfffffe, 16'h0000);
		`CHK(rsp_rdata, 16'ha5c3)
		$display("done top");
	endtask
	// Hold raised just before an access, granted after it, then withdrawn
	task automatic t_hold(input logic mode);
		int t;
		@(negedge mclk);
		dram_release_mode = mode;
		bus_hold_request = 1;
		acc(1, 1, 24'h000060, 16'h0f0f);
		`CHK(bus_hold_grant, 1'b0)
		for (t = 0; t < 50 && bus_hold_grant !== 1'b1; t++) @(negedge mclk);
		if (t == 50) expire();
		`CHK({addr_oe, ctl_oe, data_oe}, 3'h0)
		`CHK(dram_oe, ~mode)
		req_valid = 1;
		repeat (6) begin
			@(negedge mclk);
			`CHK({req_ready, addr_oe}, 2'h0)
		end
		req_valid = 0;
		bus_hold_request = 0;
		for (t = 0; t < 50 && bus_hold_grant !== 1'b0; t++) @(negedge mclk);
		if (t == 50) expire();
		`CHK(ctl_oe, 1'b0)
		for (t = 0; t < 50 && ctl_oe !== 1'b1; t++) @(negedge mclk);
		if (t == 50) expire();
		`CHK({addr_oe, bus_hold_grant}, 2'h2)
		$display("done hold %0d", mode);
	endtask
	// Reset again with the strap at 16 bits; an unmapped word then takes one cycle
	task automatic t_strap16;
		@(negedge mclk);
		rst = 1;
		bus_width_strap = ~EMBI_STRAP_BUS8;
		repeat (20) @(negedge mclk);
		rst = 0;
		t_reset();
		narrow = 0;
		acc(1, 1, 24'h800070, 16'h6789);
		`CHK({n_wr, n_hb}, {32'd1, 32'd1})
		acc(0, 1, 24'h800070, 16'h0000);
		`CHK(rsp_rdata, 16'h6789)
		`CHK(n_rd, 1)
		$display("done strap16");
	endtask
	initial begin
		{rst, req_valid, req_write, req_word, narrow, bus_hold_request} = 6'h20;
		{req_addr, req_wdata, dram_release_mode} = '0;
		{wr_q, hb_q, rd_q} = 3'h7;
		dram_in = 3'h7;
		{mismatches, samples_checked, n_wr, n_hb, n_rd} = '0;
		area_base = {24'hfe0000, 24'h200000, 24'h100000, 24'h000000};
		area_mask = {24'h01ffff, 24'h00ffff, 24'h00ffff, 24'h00ffff};
		area_en = 4'hf;
		area_bus16 = 4'hd;
		bus_width_strap = EMBI_STRAP_BUS8;
		repeat (20) @(negedge mclk);
		rst = 0;
		t_reset();
		t_word16();
		t_byte16();
		t_narrow(24'h100040, 4'hd);
		t_narrow(24'h800050, 4'hf);
		t_top();
		t_hold(1'b1);
		t_hold(1'b0);
		t_strap16();
		conclude();
	end
endmodule // embi_bus_test
